// *** common/otp_access_pkg.sv ***
package otp_access_pkg;

	// ----------------------------------------
	// command opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_SETF = 8'h1f;
	localparam logic [7:0] OP_GETF = 8'h0f;
	localparam logic [7:0] OP_PAGE_READ = 8'h13;
	localparam logic [7:0] OP_READ_CACHE = 8'h03;
	localparam logic [7:0] OP_LOAD_X1 = 8'h02;
	localparam logic [7:0] OP_LOAD_X4 = 8'h32;
	localparam logic [7:0] OP_PROG_EXEC = 8'h10;

	// ----------------------------------------
	// feature addresses, fields and resets
	// ----------------------------------------
	localparam logic [7:0] FEAT_PROTECT = 8'ha0;
	localparam logic [7:0] FEAT_CONFIG = 8'hb0;
	localparam logic [7:0] FEAT_STATUS = 8'hc0;
	localparam int CFG_LOCK_BIT = 7;
	localparam int CFG_EN_BIT = 6;
	localparam int BP_LSB = 3;
	localparam int BP_WIDTH = 4;
	localparam int STAT_WEL_BIT = 1;
	localparam int STAT_FAIL_BIT = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] PROT_RESET = 8'h00;

	// ----------------------------------------
	// extra region page map
	// ----------------------------------------
	localparam int ROW_W = 16;
	localparam logic [15:0] PAGE_UID = 16'h0000;
	localparam logic [15:0] PAGE_PARAM = 16'h0001;
	localparam logic [15:0] PAGE_OTP_FIRST = 16'h0002;
	localparam logic [15:0] PAGE_OTP_LAST = 16'h001a;
	localparam int PAGE_BYTES = 2176;
	localparam int UID_COPY_BYTES = 32;
	localparam int UID_COPIES = 16;
	localparam int PARAM_COPY_BYTES = 256;
	localparam int PARAM_COPIES = 3;
	localparam int LOCK_SLOT = 31;

	// ----------------------------------------
	// frame lengths in bytes, opcode included
	// ----------------------------------------
	localparam logic [3:0] NB_FEAT = 4'h3;
	localparam logic [3:0] NB_LOAD = 4'h3;
	localparam logic [3:0] NB_ADDR = 4'h4;

	typedef enum logic [2:0] {ST_BOOT, ST_BOOT_RD, ST_IDLE, ST_EXEC, ST_DECIDE} ctrl_state_t;

	// parameter page content, replicated per copy, zero elsewhere
	function automatic logic [7:0] param_byte(input logic [11:0] col);
		logic [7:0] b;
		b = 8'h00;
		if (col < 12'(PARAM_COPY_BYTES * PARAM_COPIES)) begin
			case (col[7:0])
				8'h00: b = 8'h4f;
				8'h01: b = 8'h4e;
				8'h02: b = 8'h46;
				8'h03: b = 8'h49;
				8'h08: b = 8'h06;
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction : param_byte

endpackage : otp_access_pkg

// *** rtl/otp_used_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module otp_used_mem #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// clock
	input wire logic clk,
	// write side, sets a flag
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	// registered read side
	input wire logic [AW-1:0] rd_addr,
	output logic rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0] bits;
		logic rd_data;
	} mem_t;

	// flags model nonvolatile cells: no reset, erased state at start
	mem_t m = '0;
	mem_t next_m;

	if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
		$error("otp_used_mem: depth does not fit address width");
	end

	always_comb begin
		next_m = m;
		next_m.rd_data = m.bits[rd_addr];
		if (wr_en) begin
			next_m.bits[wr_addr] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		m <= next_m;
	end

	assign rd_data = m.rd_data;

endmodule : otp_used_mem

`default_nettype wire

// *** rtl/otp_param_page_access.sv ***
`timescale 1ns/1ps
`default_nettype none

module otp_param_page_access #(
	parameter int MEM_DEPTH = 32
) (
	// system clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// serial link
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	// requests to the array engine
	output logic arr_req,
	output logic arr_write,
	output logic arr_extra,
	output logic [otp_access_pkg::ROW_W-1:0] arr_row,
	output logic op_reject
);
	import otp_access_pkg::*;

	localparam int MEM_AW = $clog2(MEM_DEPTH);

	if (MEM_DEPTH <= LOCK_SLOT || MEM_DEPTH > 256) begin : g_chk
		$error("otp_param_page_access: MEM_DEPTH out of range");
	end

	// ----------------------------------------
	// link domain state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] bitcnt;
		logic [3:0] nbytes;
		logic miso;
	} link_cnt_t;

	typedef struct packed {
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [11:0] col;
		logic [7:0] tx;
		logic [7:0] s1_prot;
		logic [7:0] s2_prot;
		logic [7:0] s1_cfg;
		logic [7:0] s2_cfg;
		logic [7:0] s1_stat;
		logic [7:0] s2_stat;
		logic s1_param;
		logic s2_param;
		logic [3:0] nbytes;
	} link_data_t;

	// ----------------------------------------
	// system domain state
	// ----------------------------------------
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		ctrl_state_t st;
		logic [7:0] op;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] a3;
		logic [3:0] nb;
		logic [7:0] cfg;
		logic [7:0] prot;
		logic write_latch_flag;
		logic fail;
		logic loaded;
		logic perm_lock;
		logic last_param;
		logic arr_req;
		logic arr_write;
		logic arr_extra;
		logic [ROW_W-1:0] arr_row;
		logic reject;
	} sys_t;

	link_cnt_t lc, next_lc;
	link_data_t ld, next_ld;
	sys_t sy, next_sy;

	logic [7:0] byte_now;
	logic byte_done;
	logic tx_load;
	logic [7:0] tx_val;
	logic [7:0] stat_byte;
	logic frame_end;
	logic [ROW_W-1:0] row;
	logic en;
	logic lock_bit;
	logic bp_clear;
	logic otp_page;
	logic mem_wr;
	logic [MEM_AW-1:0] mem_waddr;
	logic [MEM_AW-1:0] mem_raddr;
	logic mem_rdata;

	// ----------------------------------------
	// link side: byte assembly and readout
	// ----------------------------------------
	assign byte_now = {ld.shift[6:0], mosi};
	assign byte_done = (lc.bitcnt == 3'h7);
	assign tx_load = byte_done && ((ld.opcode == OP_GETF && lc.nbytes == 4'h1) ||
		(ld.opcode == OP_READ_CACHE && lc.nbytes >= 4'h3));

	always_comb begin
		next_lc = lc;
		next_ld = ld;
		tx_val = 8'h00;
		next_ld.s1_prot = sy.prot;
		next_ld.s2_prot = ld.s1_prot;
		next_ld.s1_cfg = sy.cfg;
		next_ld.s2_cfg = ld.s1_cfg;
		next_ld.s1_stat = stat_byte;
		next_ld.s2_stat = ld.s1_stat;
		next_ld.s1_param = sy.last_param;
		next_ld.s2_param = ld.s1_param;
		next_lc.bitcnt = lc.bitcnt + 3'h1;
		next_ld.shift = byte_now;
		if (byte_done) begin
			if (lc.nbytes != 4'hf) begin
				next_lc.nbytes = lc.nbytes + 4'h1;
				// byte count kept where cs_n high cannot clear it
				next_ld.nbytes = lc.nbytes + 4'h1;
			end
			case (lc.nbytes)
				4'h0: next_ld.opcode = byte_now;
				4'h1: next_ld.b1 = byte_now;
				4'h2: next_ld.b2 = byte_now;
				4'h3: next_ld.b3 = byte_now;
				default: next_ld.b3 = ld.b3;
			endcase
			if (lc.nbytes == 4'h2) begin
				next_ld.col = {ld.b1[3:0], byte_now};
			end
		end
		if (ld.opcode == OP_GETF) begin
			case (byte_now)
				FEAT_PROTECT: tx_val = ld.s2_prot;
				FEAT_CONFIG: tx_val = ld.s2_cfg;
				FEAT_STATUS: tx_val = ld.s2_stat;
				default: tx_val = 8'h00;
			endcase
		end else begin
			tx_val = ld.s2_param ? param_byte(ld.col) : 8'h00;
		end
		if (tx_load) begin
			next_lc.miso = tx_val[7];
			next_ld.tx = {tx_val[6:0], 1'b0};
			if (ld.opcode == OP_READ_CACHE) begin
				next_ld.col = ld.col + 12'h001;
			end
		end else begin
			next_lc.miso = ld.tx[7];
			next_ld.tx = {ld.tx[6:0], 1'b0};
		end
	end

	// counters restart with every frame; the clock stands still between frames
	always_ff @(posedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			lc <= '0;
		end else begin
			lc <= next_lc;
		end
	end

	// held words stay stable after the frame for the system side to take
	always_ff @(posedge spi_clk) begin
		ld <= next_ld;
	end

	// ----------------------------------------
	// system side: decode of finished frames
	// ----------------------------------------
	assign stat_byte = {4'h0, sy.fail, 1'b0, sy.write_latch_flag, 1'b0};
	assign frame_end = sy.cs_s2 & ~sy.cs_s3;
	assign row = {sy.a2, sy.a3};
	// enable alone or with lock selects extra
	assign en = sy.cfg[CFG_EN_BIT];
	assign lock_bit = sy.cfg[CFG_LOCK_BIT];
	assign bp_clear = (sy.prot[BP_LSB +: BP_WIDTH] == '0);
	assign otp_page = (row >= PAGE_OTP_FIRST) && (row <= PAGE_OTP_LAST);
	assign mem_raddr = (sy.st == ST_BOOT) ? MEM_AW'(LOCK_SLOT) : sy.a3[MEM_AW-1:0];

	always_comb begin
		next_sy = sy;
		next_sy.cs_s1 = cs_n;
		next_sy.cs_s2 = sy.cs_s1;
		next_sy.cs_s3 = sy.cs_s2;
		next_sy.arr_req = 1'b0;
		next_sy.reject = 1'b0;
		mem_wr = 1'b0;
		mem_waddr = sy.a3[MEM_AW-1:0];
		case (sy.st)
			ST_BOOT: next_sy.st = ST_BOOT_RD;
			ST_BOOT_RD: begin
				next_sy.perm_lock = mem_rdata;
				next_sy.st = ST_IDLE;
			end
			ST_IDLE: begin
				if (frame_end) begin
					next_sy.op = ld.opcode;
					next_sy.a1 = ld.b1;
					next_sy.a2 = ld.b2;
					next_sy.a3 = ld.b3;
					next_sy.nb = ld.nbytes;
					next_sy.st = ST_EXEC;
				end
			end
			ST_EXEC: next_sy.st = ST_DECIDE;
			ST_DECIDE: begin
				next_sy.st = ST_IDLE;
				case (sy.op)
					OP_WREN: next_sy.write_latch_flag = 1'b1;
					OP_WRDI: next_sy.write_latch_flag = 1'b0;
					OP_SETF: begin
						if (sy.nb >= NB_FEAT && sy.a1 == FEAT_PROTECT) begin
							next_sy.prot = sy.a2;
						end else if (sy.nb >= NB_FEAT && sy.a1 == FEAT_CONFIG) begin
							next_sy.cfg = sy.a2;
						end
					end
					OP_LOAD_X1, OP_LOAD_X4: begin
						if (sy.nb >= NB_LOAD) begin
							next_sy.loaded = 1'b1;
						end
					end
					OP_PAGE_READ: begin
						if (sy.nb >= NB_ADDR) begin
							next_sy.arr_req = 1'b1;
							next_sy.arr_write = 1'b0;
							next_sy.arr_row = row;
							next_sy.last_param = 1'b0;
							if (en && row <= PAGE_OTP_LAST) begin
								next_sy.arr_extra = 1'b1;
								next_sy.last_param = (row == PAGE_PARAM);
							end else if (en) begin
								next_sy.arr_req = 1'b0;
								next_sy.reject = 1'b1;
							end else begin
								next_sy.arr_extra = 1'b0;
							end
						end
					end
					OP_PROG_EXEC: begin
						if (sy.nb >= NB_ADDR && sy.write_latch_flag) begin
							next_sy.write_latch_flag = 1'b0;
							next_sy.loaded = 1'b0;
							next_sy.fail = 1'b0;
							if (en && lock_bit) begin
								if (bp_clear) begin
									next_sy.perm_lock = 1'b1;
									mem_wr = 1'b1;
									mem_waddr = MEM_AW'(LOCK_SLOT);
								end else begin
									next_sy.fail = 1'b1;
									next_sy.reject = 1'b1;
								end
							end else if (en) begin
								if (otp_page && !sy.perm_lock && bp_clear && !mem_rdata && sy.loaded) begin
									next_sy.arr_req = 1'b1;
									next_sy.arr_write = 1'b1;
									next_sy.arr_extra = 1'b1;
									next_sy.arr_row = row;
									mem_wr = 1'b1;
								end else begin
									next_sy.fail = 1'b1;
									next_sy.reject = 1'b1;
								end
							end else begin
								next_sy.arr_req = 1'b1;
								next_sy.arr_write = 1'b1;
								next_sy.arr_extra = 1'b0;
								next_sy.arr_row = row;
							end
						end
					end
					default: next_sy.st = ST_IDLE;
				endcase
			end
			default: next_sy.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sy <= '0;
			sy.cs_s1 <= 1'b1;
			sy.cs_s2 <= 1'b1;
			sy.cs_s3 <= 1'b1;
			sy.st <= ST_BOOT;
			sy.cfg <= CFG_RESET;
			sy.prot <= PROT_RESET;
		end else begin
			sy <= next_sy;
		end
	end

	otp_used_mem #(
		.DEPTH(MEM_DEPTH),
		.AW(MEM_AW)
	) u_used (
		.clk(sys_clk),
		.wr_en(mem_wr),
		.wr_addr(mem_waddr),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	assign miso = lc.miso;
	assign arr_req = sy.arr_req;
	assign arr_write = sy.arr_write;
	assign arr_extra = sy.arr_extra;
	assign arr_row = sy.arr_row;
	assign op_reject = sy.reject;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_prog_decide;
		sy.st == ST_DECIDE && sy.op == OP_PROG_EXEC && sy.nb >= NB_ADDR;
	endsequence

	sequence s_lock_cmd;
		s_prog_decide and (sy.write_latch_flag && en && lock_bit && bp_clear);
	endsequence

	sequence s_locked;
		(sy.perm_lock && sy.st == ST_IDLE && !sy.arr_req) ##1 sy.perm_lock;
	endsequence

	property p_wel_gate;
		@(posedge sys_clk) disable iff (srst)
		(sy.st == ST_DECIDE && sy.op == OP_PROG_EXEC && !sy.write_latch_flag) |=> !sy.arr_req && !sy.reject;
	endproperty
	a_wel_gate: assert property (p_wel_gate) else $error("program ran without write latch");

	property p_lock_ro;
		@(posedge sys_clk) disable iff (srst)
		(sy.arr_req && sy.arr_extra && $past(sy.perm_lock)) |-> !sy.arr_write;
	endproperty
	a_lock_ro: assert property (p_lock_ro) else $error("locked otp area programmed");

	property p_extra_map;
		@(posedge sys_clk) disable iff (srst)
		(sy.arr_req && sy.arr_extra) |-> sy.arr_row <= PAGE_OTP_LAST;
	endproperty
	a_extra_map: assert property (p_extra_map) else $error("extra request beyond page map");

	property p_main_route;
		@(posedge sys_clk) disable iff (srst)
		(sy.st == ST_DECIDE && !en) |=> !(sy.arr_req && sy.arr_extra);
	endproperty
	a_main_route: assert property (p_main_route) else $error("extra page used while disabled");

	property p_ro_pages;
		@(posedge sys_clk) disable iff (srst)
		(sy.arr_req && sy.arr_write && sy.arr_extra) |-> sy.arr_row >= PAGE_OTP_FIRST;
	endproperty
	a_ro_pages: assert property (p_ro_pages) else $error("read only page programmed");

	property p_once;
		@(posedge sys_clk) disable iff (srst)
		(s_prog_decide and (sy.write_latch_flag && en && !lock_bit && mem_rdata)) |=> !sy.arr_req && sy.reject;
	endproperty
	a_once: assert property (p_once) else $error("otp page programmed twice");

	property p_cfg_reset;
		@(posedge sys_clk) disable iff (srst)
		$fell(srst) |-> !sy.cfg[CFG_LOCK_BIT] && !sy.cfg[CFG_EN_BIT];
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("lock bit not clear after reset");

	property p_lock_seq;
		@(posedge sys_clk) disable iff (srst)
		s_lock_cmd |=> s_locked;
	endproperty
	a_lock_seq: assert property (p_lock_seq) else $error("lock sequence did not lock");

	property p_wel_clear;
		@(posedge sys_clk) disable iff (srst)
		(s_prog_decide and sy.write_latch_flag) |=> !sy.write_latch_flag;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("write latch kept after program");

	property p_param_read;
		@(posedge sys_clk) disable iff (srst)
		(sy.st == ST_DECIDE && sy.op == OP_PAGE_READ && sy.nb >= NB_ADDR && en && row == PAGE_PARAM)
		|=> (sy.arr_req && !sy.arr_write && sy.arr_extra && sy.last_param) ##1 !sy.arr_req;
	endproperty
	a_param_read: assert property (p_param_read) else $error("parameter page read misrouted");

endmodule : otp_param_page_access

`default_nettype wire

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// link to the device
	output logic spi_clk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ----------------------------------------
	// one frame of n bytes, msb first
	// ----------------------------------------
	task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = 64'h0000_0000_0000_0000;
		#17;
		cs_n = 1'b0;
		for (int i = 8 * n - 1; i >= 0; i--) begin
			mosi = tx[i];
			#62.5;
			// sample before the edge that updates the device output
			rx = {rx[62:0], miso};
			spi_clk = 1'b1;
			#62.5;
			spi_clk = 1'b0;
		end
		#40;
		cs_n = 1'b1;
		// released line shows the inverse, not a held value
		mosi = ~mosi;
		#400;
	endtask : xfer

endmodule : spi_host_model
`default_nettype wire

// *** tb/otp_param_page_access_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module otp_param_page_access_bench;
	import otp_access_pkg::*;
	localparam logic [18:0] REJ = 19'h4_0000;
	localparam logic [15:0] COLS [4] = '{16'h0000, 16'h0100, 16'h0300, 16'h0007};
	localparam logic [31:0] PDAT [4] = '{32'h4f4e_4649, 32'h4f4e_4649, 32'h0000_0000, 32'h0006_0000};
	logic sys_clk, srst, spi_clk, cs_n, mosi, miso, quiet;
	logic arr_req, arr_write, arr_extra, op_reject;
	logic [15:0] arr_row;
	logic [18:0] got;
	logic [63:0] rx;
	logic [31:0] seed;
	logic [18:0] exp_q[$];
	int err_count, comparisons;

	// ----------------------------------------
	// clock, device and host
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	otp_param_page_access #(.MEM_DEPTH(32)) u_dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.spi_clk(spi_clk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.arr_req(arr_req),
		.arr_write(arr_write),
		.arr_extra(arr_extra),
		.arr_row(arr_row),
		.op_reject(op_reject)
	);

	spi_host_model u_host (
		.spi_clk(spi_clk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	function automatic logic [18:0] rq(input logic w, input logic x, input logic [15:0] row);
		return {1'b0, w, x, row};
	endfunction : rq

	task automatic fr(input int n, input logic [63:0] tx);
		u_host.xfer(n, tx, rx);
	endtask : fr

	task automatic feat(input logic [7:0] a, input logic [7:0] d);
		fr(3, 64'({OP_SETF, a, d}));
	endtask : feat

	task automatic getf(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		fr(3, 64'({OP_GETF, a, 8'h00}));
		`CHK(rx[7:0] & m, e)
	endtask : getf

	task automatic pread(input logic [15:0] row);
		fr(4, 64'({OP_PAGE_READ, 8'h00, row}));
	endtask : pread

	task automatic prog(input logic [15:0] row, input logic [7:0] lop);
		seed = xs(seed);
		fr(4, 64'({lop, 16'h0000, seed[7:0]}));
		fr(1, 64'(OP_WREN));
		fr(4, 64'({OP_PROG_EXEC, 8'h00, row}));
	endtask : prog

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask : tend

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	// ----------------------------------------
	// result watcher and watchdog
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!quiet && (arr_req === 1'b1 || op_reject === 1'b1)) begin
			got = op_reject ? REJ : {1'b0, arr_write, arr_extra, arr_row};
			if (exp_q.size() == 0) begin
				`CHK(got, 19'h7_ffff)
			end else begin
				`CHK(got, exp_q.pop_front())
			end
		end
	end

	initial begin
		#500_000;
		err_count++;
		results();
	end

	initial begin
		srst = 1'b1;
		quiet = 1'b0;
		seed = 32'h0000_dc45;
		err_count = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		getf(FEAT_CONFIG, 8'hff, CFG_RESET);
		getf(FEAT_PROTECT, 8'hff, PROT_RESET);
		seed = xs(seed);
		exp_q.push_back(rq(1'b0, 1'b0, seed[15:0]));
		pread(seed[15:0]);
		tend("reset and main read");
		feat(FEAT_CONFIG, 8'h40);
		getf(FEAT_CONFIG, 8'hff, 8'h40);
		exp_q.push_back(rq(1'b0, 1'b1, PAGE_PARAM));
		pread(PAGE_PARAM);
		for (int i = 0; i < 4; i++) begin
			fr(8, {OP_READ_CACHE, COLS[i], 8'h00, 32'h0000_0000});
			`CHK(rx[31:0], PDAT[i])
		end
		exp_q.push_back(REJ);
		pread(PAGE_OTP_LAST + 16'h0001);
		exp_q.push_back(rq(1'b0, 1'b1, PAGE_UID));
		pread(PAGE_UID);
		tend("extra reads");
		fr(4, 64'({OP_LOAD_X1, 24'h00_0000}));
		fr(4, 64'({OP_PROG_EXEC, 8'h00, PAGE_OTP_FIRST}));
		getf(FEAT_STATUS, 8'h0a, 8'h00);
		fr(1, 64'(OP_WREN));
		getf(FEAT_STATUS, 8'h02, 8'h02);
		feat(FEAT_PROTECT, 8'h08);
		exp_q.push_back(REJ);
		prog(PAGE_OTP_FIRST, OP_LOAD_X1);
		getf(FEAT_STATUS, 8'h08, 8'h08);
		feat(FEAT_PROTECT, 8'h00);
		for (int p = 2; p < 4; p++) begin
			exp_q.push_back(rq(1'b1, 1'b1, 16'(p)));
			prog(16'(p), p[0] ? OP_LOAD_X4 : OP_LOAD_X1);
		end
		getf(FEAT_STATUS, 8'h08, 8'h00);
		for (int p = 0; p < 3; p++) begin
			exp_q.push_back(REJ);
			prog(16'(p), OP_LOAD_X1);
		end
		getf(FEAT_STATUS, 8'h08, 8'h08);
		tend("programming");
		feat(FEAT_CONFIG, 8'h80);
		exp_q.push_back(rq(1'b0, 1'b0, PAGE_PARAM));
		pread(PAGE_PARAM);
		feat(FEAT_CONFIG, 8'h00);
		exp_q.push_back(rq(1'b1, 1'b0, 16'h0003));
		prog(16'h0003, OP_LOAD_X1);
		tend("state decode");
		feat(FEAT_CONFIG, 8'hc0);
		feat(FEAT_PROTECT, 8'h08);
		exp_q.push_back(REJ);
		prog(16'h0000, OP_LOAD_X1);
		feat(FEAT_PROTECT, 8'h00);
		quiet = 1'b1;
		prog(16'h0000, OP_LOAD_X1);
		quiet = 1'b0;
		feat(FEAT_CONFIG, 8'h40);
		exp_q.push_back(REJ);
		prog(16'h0004, OP_LOAD_X1);
		exp_q.push_back(rq(1'b0, 1'b1, 16'h0004));
		pread(16'h0004);
		tend("area lock");
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		getf(FEAT_CONFIG, 8'hff, 8'h00);
		feat(FEAT_CONFIG, 8'h40);
		exp_q.push_back(REJ);
		prog(16'h0005, OP_LOAD_X1);
		repeat (10) @(posedge sys_clk);
		`CHK(exp_q.size(), 0)
		tend("lock after reset");
		results();
	end

endmodule : otp_param_page_access_bench
`default_nettype wire
